// ===== inc/tfo_pkg.sv
package tfo_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_TRIG = 8'h04;
   localparam logic [7:0] OFS_MAIN = 8'h08;
   localparam logic [7:0] OFS_CNT = 8'h0c;
   localparam logic [7:0] OFS_CONA = 8'h10;
   localparam logic [7:0] OFS_CONB = 8'h14;
   // Status/output control fields
   localparam int BIT_FLAG_B = 7;
   localparam int BIT_FLAG_A = 6;
   localparam int BIT_WRAP = 5;
   localparam logic [7:0] STAT_RSVD = 8'h10;
   // Trigger control fields
   localparam int BIT_EDGE_HI = 4;
   localparam int BIT_GATE = 2;
   localparam int BIT_XCLK = 0;
   localparam logic [7:0] TRIG_RSVD = 8'he2;
   // Main control fields
   localparam int BIT_IEN_B = 7;
   localparam int BIT_IEN_A = 6;
   localparam int BIT_IEN_W = 5;
   localparam int BIT_CLR_HI = 4;
   localparam int BIT_CKS_HI = 2;
   // Reset values and counter maximum
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CONST_RST = 8'hff;
   localparam logic [7:0] CNT_MAX = 8'hff;
   // Output action codes
   localparam logic [1:0] ACT_HOLD = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOG = 2'h3;
   // Clear source codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MA = 2'h1;
   localparam logic [1:0] CLR_MB = 2'h2;
   localparam logic [1:0] CLR_PIN = 2'h3;
   // Prescaler width: divide by 128 at most
   localparam int PRESC_W = 7;
endpackage

// ===== src/tfo_timer.sv
`timescale 1ns/1ps
module tfo_timer
   import tfo_pkg::*;
#(
   parameter int ADR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_count_pin_i,
   input wire logic ext_clear_pin_i,
   input wire logic trig_in_pin_i,
   output logic wave_out_pin_o,
   output logic irq_o
);

   // Software-visible state
   logic [2:0] flags; // Flag B, flag A, wrap flag
   logic [2:0] armed; // Flag seen as 1 by a read
   logic [1:0] act_b; // Action on match B
   logic [1:0] act_a; // Action on match A
   logic [1:0] edge_sel; // Trigger edge code
   logic gate_en; // Trigger gate enable
   logic extra_clk; // Extra clock-select bit
   logic [7:0] main_ctrl; // Enables, clear source, clock select
   logic [7:0] cnt; // Up counter
   logic [7:0] const_a; // Compare constant A
   logic [7:0] const_b; // Compare constant B
   // Internal state
   logic [PRESC_W-1:0] presc; // Free-running prescaler
   logic [PRESC_W-1:0] presc_q; // Prescaler one cycle ago
   logic ext_cnt_q; // Count pin one cycle ago
   logic ext_clr_q; // Clear pin one cycle ago
   logic trig_q; // Trigger pin one cycle ago
   logic halted; // Counting stopped awaiting trigger
   logic wave; // Waveform output level

   // Field views of the main control register
   wire [2:0] flag_en = main_ctrl[BIT_IEN_B:BIT_IEN_W];
   wire [1:0] clr_src = main_ctrl[BIT_CLR_HI -: 2];
   wire [2:0] cks = main_ctrl[BIT_CKS_HI -: 3];

   // Bus decode
   wire req = wb_cyc_i & wb_stb_i;
   wire wr = req & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire rd_take = req & ~wb_we_i & ~wb_ack_o;
   wire sel_stat = wb_adr_i == ADR_W'(OFS_STAT);
   wire sel_trig = wb_adr_i == ADR_W'(OFS_TRIG);
   wire sel_main = wb_adr_i == ADR_W'(OFS_MAIN);
   wire sel_cnt = wb_adr_i == ADR_W'(OFS_CNT);
   wire sel_cona = wb_adr_i == ADR_W'(OFS_CONA);
   wire sel_conb = wb_adr_i == ADR_W'(OFS_CONB);
   wire [7:0] wd = wb_dat_i[7:0];

   // Register read views; reserved bits forced to one
   wire [7:0] stat_view = {flags, 1'b0, act_b, act_a} | STAT_RSVD;
   wire [7:0] trig_view = {3'h0, edge_sel, gate_en, 1'b0, extra_clk} | TRIG_RSVD;

   // Read multiplexer; unmapped addresses read as zero
   wire [7:0] rd_val = sel_stat ? stat_view :
                       sel_trig ? trig_view :
                       sel_main ? main_ctrl :
                       sel_cnt ? cnt :
                       sel_cona ? const_a :
                       sel_conb ? const_b : 8'h00;

   // Internal divided clock: bit index 2*code-1+extra, falling edge counts
   function automatic logic div_fall(input logic [PRESC_W-1:0] prev,
                                     input logic [PRESC_W-1:0] now,
                                     input logic [1:0] code,
                                     input logic xb);
      logic [2:0] idx;
      idx = 3'({code, 1'b0}) - 3'h1 + 3'(xb);
      div_fall = prev[idx] & ~now[idx];
   endfunction

   // Edge detect selected by a two-bit edge code
   function automatic logic edge_hit(input logic [1:0] code,
                                     input logic prev,
                                     input logic now);
      edge_hit = (code[0] & now & ~prev) | (code[1] & ~now & prev);
   endfunction

   // Count event selection
   wire int_tick = ~cks[2] & (cks[1:0] != 2'h0)
                   & div_fall(presc_q, presc, cks[1:0], extra_clk);
   wire ext_tick = cks[2] & edge_hit(cks[1:0], ext_cnt_q, ext_count_pin_i);
   wire tick = ce_i & ~halted & (int_tick | ext_tick);

   // Trigger and clear pin edges
   wire trig_hit = ce_i & gate_en & edge_hit(edge_sel, trig_q, trig_in_pin_i);
   wire ext_clr_pin_rise = ext_clear_pin_i & ~ext_clr_q;
   wire pin_clr = ce_i & ext_clr_pin_rise;

   // Compare matches; a constant write in the same cycle suppresses its match
   wire match_a = tick & (cnt == const_a) & ~(wr & sel_cona);
   wire match_b = tick & (cnt == const_b) & ~(wr & sel_conb);

   // Clear source selection
   wire clr = (clr_src == CLR_MA & match_a) | (clr_src == CLR_MB & match_b)
              | (clr_src == CLR_PIN & pin_clr);
   wire cnt_wr = wr & sel_cnt;
   wire wrap = tick & (cnt == CNT_MAX) & ~clr & ~cnt_wr;

   // Flag set and clear terms
   wire [2:0] flag_set = {match_b, match_a, wrap};
   wire [2:0] flag_clr = {3{wr & sel_stat}} & armed & ~wd[BIT_FLAG_B:BIT_WRAP];

   // Merge output actions of both matches
   wire [1:0] eff_b = match_b ? act_b : ACT_HOLD;
   wire [1:0] eff_a = match_a ? act_a : ACT_HOLD;
   wire any_tog = (eff_a == ACT_TOG) | (eff_b == ACT_TOG);
   wire any_high = (eff_a == ACT_HIGH) | (eff_b == ACT_HIGH);
   wire any_low = (eff_a == ACT_LOW) | (eff_b == ACT_LOW);
   wire next_wave = any_tog ? ~wave :
                    any_high ? 1'b1 :
                    any_low ? 1'b0 : wave;

   // Counter next value: clear beats write, write beats count
   wire [7:0] next_cnt = clr ? CNT_RST :
                         cnt_wr ? wd :
                         tick ? 8'(cnt + 8'h01) : cnt;

   // Bus answer: registered ack one cycle after request, data with it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= req & ~wb_ack_o;
         if (rd_take) begin
            wb_dat_o <= {24'h0, rd_val};
         end
      end
   end

   // Read-then-write clear protocol; a new set wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 3'h0;
         armed <= 3'h0;
      end else if (ce_i) begin
         flags <= (flags & ~flag_clr) | flag_set;
         // Arm on a status read showing the flag as one
         if (rd_take & sel_stat) begin
            armed <= flags;
         end else begin
            armed <= armed & ~flag_clr;
         end
      end
   end

   // Control registers, writable bits only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_b <= ACT_HOLD;
         act_a <= ACT_HOLD;
         edge_sel <= 2'h0;
         gate_en <= 1'b0;
         extra_clk <= 1'b0;
         main_ctrl <= 8'h00;
         const_a <= CONST_RST;
         const_b <= CONST_RST;
      end else if (ce_i & wr) begin
         if (sel_stat) begin
            act_b <= wd[3:2];
            act_a <= wd[1:0];
         end
         if (sel_trig) begin
            edge_sel <= wd[BIT_EDGE_HI -: 2];
            gate_en <= wd[BIT_GATE];
            extra_clk <= wd[BIT_XCLK];
         end
         if (sel_main) begin
            main_ctrl <= wd;
         end
         if (sel_cona) begin
            const_a <= wd;
         end
         if (sel_conb) begin
            const_b <= wd;
         end
      end
   end

   // Counter, prescaler and pin history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= CNT_RST;
         presc <= '0;
         presc_q <= '0;
         ext_cnt_q <= 1'b0;
         ext_clr_q <= 1'b0;
         trig_q <= 1'b0;
      end else if (ce_i) begin
         cnt <= next_cnt;
         presc <= presc + 1'b1;
         presc_q <= presc;
         ext_cnt_q <= ext_count_pin_i;
         ext_clr_q <= ext_clear_pin_i;
         trig_q <= trig_in_pin_i;
      end
   end

   // Halt after a clear while gated; a trigger edge in the same cycle wins
   // so the start request is never lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halted <= 1'b0;
      end else if (ce_i) begin
         if (!gate_en) begin
            halted <= 1'b0;
         end else if (trig_hit) begin
            halted <= 1'b0;
         end else if (clr) begin
            halted <= 1'b1;
         end
      end
   end

   // Waveform output level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wave <= 1'b0;
      end else if (ce_i) begin
         wave <= next_wave;
      end
   end

   assign wave_out_pin_o = wave;
   // Level interrupt gated by the enable bits
   assign irq_o = |(flags & flag_en);

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_flag_b;
      match_b |=> flags[2];
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("flag B not set");

   property p_flag_a;
      match_a |=> flags[1];
   endproperty
   a_flag_a: assert property (p_flag_a) else $error("flag A not set");

   property p_wrap;
      tick && cnt == CNT_MAX && !clr && !cnt_wr |=> flags[0] && cnt == CNT_RST;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap not flagged");

   property p_clear_only_armed;
      $fell(flags[1]) |-> $past(wr && sel_stat && armed[1] && !wd[BIT_FLAG_A]);
   endproperty
   a_clear_only_armed: assert property (p_clear_only_armed) else $error("bad clear");

   property p_rsvd;
      wb_ack_o && !wb_we_i && $past(sel_trig && rd_take) |-> wb_dat_o[7:5] == 3'h7
         && wb_dat_o[1];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not one");

   property p_toggle_a;
      match_a && !match_b && act_a == ACT_TOG |=> wave != $past(wave);
   endproperty
   a_toggle_a: assert property (p_toggle_a) else $error("no toggle on A");

   property p_b_high;
      match_b && act_b == ACT_HIGH && !(match_a && act_a == ACT_TOG) |=> wave;
   endproperty
   a_b_high: assert property (p_b_high) else $error("no high on B");

   property p_prio;
      match_a && match_b && act_a == ACT_LOW && act_b == ACT_HIGH |=> wave;
   endproperty
   a_prio: assert property (p_prio) else $error("priority wrong");

   property p_wave_cause;
      $changed(wave) |-> $past(match_a || match_b);
   endproperty
   a_wave_cause: assert property (p_wave_cause) else $error("wave moved alone");

   property p_halt;
      ce_i && gate_en && clr && !trig_hit |=> halted ##1 (halted || $past(trig_hit));
   endproperty
   a_halt: assert property (p_halt) else $error("no halt");

   property p_nogate;
      !gate_en && ce_i |=> !halted;
   endproperty
   a_nogate: assert property (p_nogate) else $error("halt without gate");

   property p_irq;
      irq_o == ((flags[2] && main_ctrl[BIT_IEN_B]) || (flags[1] && main_ctrl[BIT_IEN_A])
         || (flags[0] && main_ctrl[BIT_IEN_W]));
   endproperty
   a_irq: assert property (p_irq) else $error("irq not enabled");

   c_wrap: cover property (wrap);
   c_both: cover property (match_a && match_b);
   c_resume: cover property (halted ##1 trig_hit);
endmodule

// ===== sim/tfo_cpu.sv
`timescale 1ns/1ps
// Classic Wishbone master standing in for the CPU
module tfo_cpu (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   // Idle bus at time zero; only the low byte lane is used
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h1;
      dat_o = 32'h0;
   end
   // One access; held until ack is sampled, so a slow slave is safe
   // Software clears a flag only with a read of 1 before the write of 0
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= {24'h0, d};
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      q = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
   endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
   import tfo_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic trig = 1'b0; // Trigger pin driven by the bench
   logic xclr = 1'b0; // External clear pin driven by the bench
   logic cyc, stb, we, ack, wave, irq, w;
   logic [7:0] adr, q, q2, k;
   logic [3:0] sel;
   logic [31:0] wdat, rdat;
   int error_cnt = 0;
   int n_compared = 0;
   logic [7:0] rofs [7] = '{OFS_STAT, OFS_TRIG, OFS_MAIN, OFS_CNT, OFS_CONA, OFS_CONB, 8'h18};
   logic [7:0] rval [7] = '{8'h10, 8'he2, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
   logic [7:0] tv [4] = '{8'h04, 8'h14, 8'h0c, 8'h1c}; // Edge codes 00,10,01,11
   logic pv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic [7:0] sv [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
   // Free-running system clock
   initial begin
      forever #20 clk_i = ~clk_i;
   end
   tfo_cpu cpu (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // Clock enable and external count pin are tied off
   tfo_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ext_count_pin_i(1'b0), .ext_clear_pin_i(xclr),
      .trig_in_pin_i(trig), .wave_out_pin_o(wave), .irq_o(irq));
   task conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] unused;
      cpu.xfer(1'b1, a, d, unused);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      cpu.xfer(1'b0, a, 8'h00, d);
   endtask
   // Polls status until the given flags show, bounded
   task poll(input logic [7:0] fl);
      int n;
      n = 0;
      do begin
         rd(OFS_STAT, q);
         n++;
      end while ((q & fl) == 8'h00 && n < 60);
      chk(q & fl, fl, "flag set");
   endtask
   function automatic logic act(input logic [1:0] c, input logic v);
      case (c)
         ACT_LOW: return 1'b0;
         ACT_HIGH: return 1'b1;
         ACT_TOG: return !v;
         default: return v;
      endcase
   endfunction
   // Mode 0 match A, 1 match B, 2 both at once: toggle beats high beats low
   function automatic logic want(input logic [1:0] ca, input logic [1:0] cb, input int m,
      input logic v);
      if (m == 0) return act(ca, v);
      if (m == 1) return act(cb, v);
      if (ca == ACT_TOG || cb == ACT_TOG) return !v;
      if (ca == ACT_HIGH || cb == ACT_HIGH) return 1'b1;
      if (ca == ACT_LOW || cb == ACT_LOW) return 1'b0;
      return v;
   endfunction
   // Runs the counter from one step below a random constant past it, then checks pin, irq, flags
   task run_match(input logic [1:0] ca, input logic [1:0] cb, input int m);
      logic [7:0] fl;
      fl = (m == 0) ? 8'h40 : (m == 1) ? 8'h80 : 8'hc0;
      k = 8'($urandom_range(200, 2));
      wr(OFS_CONA, (m == 1) ? 8'hff : k);
      wr(OFS_CONB, (m == 0) ? 8'hff : k);
      wr(OFS_STAT, {4'h0, cb, ca});
      wr(OFS_CNT, k - 8'h01);
      wr(OFS_MAIN, 8'he1);
      poll(fl);
      wr(OFS_MAIN, 8'he0);
      @(negedge clk_i);
      w = want(ca, cb, m, w);
      chk({7'h0, wave}, {7'h0, w}, "wave level");
      chk({7'h0, irq}, 8'h01, "irq enabled");
      wr(OFS_MAIN, 8'h00);
      @(negedge clk_i);
      chk({7'h0, irq}, 8'h00, "irq masked");
      wr(OFS_STAT, fl | {4'h0, cb, ca});
      rd(OFS_STAT, q);
      chk(q & fl, fl, "flag kept on write one");
      wr(OFS_STAT, {4'h0, cb, ca});
      rd(OFS_STAT, q);
      chk(q & fl, 8'h00, "flag cleared");
   endtask
   // Watchdog sized well past the expected run of about 1200 cycles
   initial begin
      #(40 * 40000);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      conclude();
   end
   initial begin
      w = 1'b0;
      void'($urandom(19422));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk({6'h0, wave, irq}, 8'h00, "pins after reset");
      for (int i = 0; i < 7; i++) begin
         rd(rofs[i], q);
         chk(q, rval[i], "reset value");
      end
      wr(OFS_TRIG, 8'h1d);
      rd(OFS_TRIG, q);
      chk(q, 8'hff, "trigger ctrl all ones");
      wr(OFS_STAT, 8'h00);
      rd(OFS_STAT, q);
      chk(q, 8'h10, "status reserved bit");
      wr(OFS_TRIG, 8'h00);
      rd(OFS_TRIG, q);
      chk(q, 8'he2, "trigger ctrl reserved bits");
      // Wrap from ff to 00 with actions on hold
      wr(OFS_CNT, 8'hfe);
      wr(OFS_MAIN, 8'h21);
      poll(8'h20);
      wr(OFS_MAIN, 8'h00);
      // Every action code on each channel, then random same-cycle pairs
      for (int i = 0; i < 4; i++) begin
         run_match(2'(i), 2'($urandom), 0);
         run_match(2'($urandom), 2'(i), 1);
      end
      for (int i = 0; i < 4; i++) begin
         run_match(2'($urandom), 2'($urandom), 2);
      end
      // Gate on, clear on match A: counter halts at zero until the chosen edge
      wr(OFS_TRIG, 8'h04);
      wr(OFS_CONA, 8'h05);
      wr(OFS_CONB, 8'hff);
      wr(OFS_CNT, 8'h00);
      wr(OFS_MAIN, 8'h09);
      for (int i = 0; i < 4; i++) begin
         repeat (60) @(posedge clk_i);
         rd(OFS_CNT, q);
         chk(q, 8'h00, "halted after clear");
         wr(OFS_TRIG, tv[i]);
         trig <= pv[i];
         repeat (12) @(posedge clk_i);
         rd(OFS_CNT, q);
         chk({7'h0, q != 8'h00}, sv[i], "restart on edge");
      end
      // Gate off: a clear no longer halts the counter
      wr(OFS_TRIG, 8'h08);
      repeat (60) @(posedge clk_i);
      rd(OFS_CNT, q);
      repeat (5) @(posedge clk_i);
      rd(OFS_CNT, q2);
      chk({7'h0, q != q2}, 8'h01, "keeps counting");
      // Extra select bit turns divide by 4 into divide by 8: 81 edges give 10 or 11 ticks
      wr(OFS_TRIG, 8'h01);
      wr(OFS_MAIN, 8'h01);
      wr(OFS_CNT, 8'h00);
      repeat (80) @(posedge clk_i);
      rd(OFS_CNT, q);
      chk({7'h0, q >= 8'h09 && q <= 8'h0b}, 8'h01, "divide by eight");
      // Rising edge on the external clear pin resets a high count
      wr(OFS_MAIN, 8'h19);
      wr(OFS_CNT, 8'h80);
      xclr <= 1'b1;
      repeat (4) @(posedge clk_i);
      xclr <= 1'b0;
      rd(OFS_CNT, q);
      chk({7'h0, q < 8'h08}, 8'h01, "cleared by pin");
      // Clear on match B keeps the count at or below constant B
      wr(OFS_CONB, 8'h06);
      wr(OFS_MAIN, 8'h11);
      repeat (100) @(posedge clk_i);
      rd(OFS_CNT, q);
      chk({7'h0, q <= 8'h06}, 8'h01, "cleared by match B");
      conclude();
   end
endmodule
